/* File: common/gas_host_defs.svh */
// timing, address and checksum constants for the gas sensor bus host
`ifndef GAS_HOST_DEFS_SVH
`define GAS_HOST_DEFS_SVH

`define CLK_PERIOD_NS 20
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define T_SCL_NS     2500
`define T_LOW_NS     1300
`define T_HIGH_NS    600
`define T_HD_STA_NS  600
`define T_SU_STA_NS  600
`define T_SU_STO_NS  600
`define T_BUF_NS     1300

`define LOW_CYC      `NS_TO_CYC(`T_LOW_NS)
`define HIGH_CYC     (`NS_TO_CYC(`T_SCL_NS) - `LOW_CYC)
`define HD_STA_CYC   `NS_TO_CYC(`T_HD_STA_NS)
`define SU_STA_CYC   `NS_TO_CYC(`T_SU_STA_NS)
`define SU_STO_CYC   `NS_TO_CYC(`T_SU_STO_NS)
`define BUF_CYC      `NS_TO_CYC(`T_BUF_NS)

`define PWRUP_US     600
`define PWRUP_CYC    `NS_TO_CYC(`PWRUP_US * 1000)
`define MEAS_MS      40
`define MEAS_CYC     `NS_TO_CYC(`MEAS_MS * 1000000)
`define POLL_US      1000
`define POLL_CYC     `NS_TO_CYC(`POLL_US * 1000)

`define DEV_ADDR     7'h58
`define WRITE_BIT    1'b0
`define READ_BIT     1'b1
`define BIT_LAST     4'h8
`define IDX_CMD_MSB  4'h1
`define IDX_CMD_LAST 4'h2
`define IDX_DATA_CRC 4'h5

`define CRC8_POLY    8'h07
`define CRC8_INIT    8'h00
`define CRC3_POLY    3'h3
`define CRC3_INIT    3'h0

`endif

/* File: common/gas_host_pkg.sv */
// types shared by the gas sensor bus host
package gas_host_pkg;

  typedef struct packed {
    logic [15:0] cmd;
    logic        addCrc3;
    logic        hasData;
    logic [15:0] data;
    logic [2:0]  words;
  } req_t;

  typedef struct packed {
    logic [15:0] value;
    logic        crcOk;
  } word_t;

  typedef enum logic [8:0] {
    S_PWRUP = 9'h001,
    S_IDLE  = 9'h002,
    S_START = 9'h004,
    S_LOW   = 9'h008,
    S_HIGH  = 9'h010,
    S_NEXT  = 9'h020,
    S_STOP  = 9'h040,
    S_WAIT  = 9'h080,
    S_SPARE = 9'h100
  } state_t;

endpackage : gas_host_pkg

/* File: rtl/gas_sensor_host.sv */
// bus host for the gas sensor: command writes, result polling and word fifo
`timescale 1ns/1ps
`include "gas_host_defs.svh"

module word_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] memReg [DEPTH];
  logic [AW-1:0]    wrReg, wrNext, rdReg, rdNext;
  logic [AW:0]      cntReg, cntNext;
  logic             wrEn, rdEn;

  assign inReady  = (cntReg != (AW+1)'(DEPTH));
  assign outValid = (cntReg != '0);
  assign outData  = memReg[rdReg];

  always_comb begin
    wrEn   = inValid && inReady;
    rdEn   = outValid && outReady;
    wrNext = wrEn ? ((wrReg == AW'(DEPTH - 1)) ? '0 : wrReg + 1'b1) : wrReg;
    rdNext = rdEn ? ((rdReg == AW'(DEPTH - 1)) ? '0 : rdReg + 1'b1) : rdReg;
    cntNext = cntReg + (AW+1)'(wrEn) - (AW+1)'(rdEn);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrReg  <= '0;
      rdReg  <= '0;
      cntReg <= '0;
    end else begin
      wrReg  <= wrNext;
      rdReg  <= rdNext;
      cntReg <= cntNext;
    end
    if (wrEn) begin
      memReg[wrReg] <= inData;
    end
  end
endmodule : word_fifo

module gas_sensor_host #(
  parameter int         PWRUP_CYC  = `PWRUP_CYC,
  parameter int         MEAS_CYC   = `MEAS_CYC,
  parameter int         POLL_CYC   = `POLL_CYC,
  parameter int         FIFO_DEPTH = 4,
  parameter logic [7:0] CRC8_POLY  = `CRC8_POLY,
  parameter logic [7:0] CRC8_INIT  = `CRC8_INIT,
  parameter logic [2:0] CRC3_POLY  = `CRC3_POLY,
  parameter logic [2:0] CRC3_INIT  = `CRC3_INIT
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire gas_host_pkg::req_t   reqIn,
  input  wire logic                 reqValid,
  output logic                      reqReady,
  output gas_host_pkg::word_t       respOut,
  output logic                      respValid,
  input  wire logic                 respReady,
  output logic                      busy,
  output logic                      donePulse,
  output logic                      refusedErr,
  input  wire logic                 sclIn,
  output logic                      sclOut,
  output logic                      sclOe_n,
  input  wire logic                 sdaIn,
  output logic                      sdaOut,
  output logic                      sdaOe_n
);
  import gas_host_pkg::*;

  localparam int TW = $clog2(PWRUP_CYC + MEAS_CYC + POLL_CYC + 1);

  state_t      stateReg, stateNext;
  req_t        reqReg, reqNext;
  logic [TW-1:0] cntReg, cntNext, cntDec;
  logic [3:0]  bitReg, bitNext, idxReg, idxNext;
  logic [8:0]  txReg, txNext, rxReg, rxNext;
  logic [1:0]  posReg, posNext;
  logic [2:0]  leftReg, leftNext;
  logic [15:0] wordReg, wordNext;
  logic        rdReg, rdNext, pendReg, pendNext, refReg, refNext;
  logic        sclOeReg, sclOeNext, sdaOeReg, sdaOeNext;
  logic        doneReg, doneNext, readyReg, busyReg, loadReg;
  logic [1:0]  sclSyncReg, sdaSyncReg;
  logic        sclSync, sdaSync, ackSeen, cntZero, push, fifoInReady;
  logic [1:0]  nPos;
  logic [2:0]  nLeft;
  logic [7:0]  wrByte;
  word_t       pushData;

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC8_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC8_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8

  function automatic logic [2:0] crc3(input logic [12:0] d);
    logic [2:0] c;
    c = CRC3_INIT;
    for (int i = 12; i >= 0; i--) begin
      c = (c[2] ^ d[i]) ? ({c[1:0], 1'b0} ^ CRC3_POLY) : {c[1:0], 1'b0};
    end
    return c;
  endfunction : crc3

  // only the second stage of each synchroniser is read
  assign sclSync = sclSyncReg[1];
  assign sdaSync = sdaSyncReg[1];

  assign reqReady   = readyReg;
  assign busy       = busyReg;
  assign donePulse  = doneReg;
  assign refusedErr = refReg;
  assign sclOut     = 1'b0;
  assign sdaOut     = 1'b0;
  assign sclOe_n    = sclOeReg;
  assign sdaOe_n    = sdaOeReg;

  word_fifo #(.WIDTH($bits(word_t)), .DEPTH(FIFO_DEPTH)) respFifo (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .inData   (pushData),
    .inValid  (push),
    .inReady  (fifoInReady),
    .outData  (respOut),
    .outValid (respValid),
    .outReady (respReady)
  );

  // byte written at the next write index
  always_comb begin
    case (idxReg + 4'h1)
      4'h1:    wrByte = reqReg.cmd[15:8];
      4'h2:    wrByte = reqReg.cmd[7:0];
      4'h3:    wrByte = reqReg.data[15:8];
      4'h4:    wrByte = reqReg.data[7:0];
      default: wrByte = crc8(reqReg.data);
    endcase
  end

  always_comb begin
    stateNext = stateReg;
    reqNext   = reqReg;
    cntDec    = cntReg - 1'b1;
    cntNext   = cntDec;
    cntZero   = (cntReg == '0);
    bitNext   = bitReg;
    idxNext   = idxReg;
    txNext    = txReg;
    rxNext    = rxReg;
    posNext   = posReg;
    leftNext  = leftReg;
    wordNext  = wordReg;
    rdNext    = rdReg;
    pendNext  = pendReg;
    refNext   = refReg;
    sclOeNext = sclOeReg;
    sdaOeNext = sdaOeReg;
    doneNext  = 1'b0;
    ackSeen   = ~rxReg[0];
    push      = 1'b0;
    pushData  = '{value: wordReg, crcOk: (crc8(wordReg) == rxReg[8:1])};
    nPos      = (posReg == 2'h2) ? 2'h0 : posReg + 2'h1;
    nLeft     = (posReg == 2'h2) ? leftReg - 3'h1 : leftReg;
    case (stateReg)
      S_PWRUP: begin
        if (cntZero) begin
          stateNext = S_IDLE;
        end
      end
      S_IDLE: begin
        cntNext = cntReg;
        if (reqValid && readyReg) begin
          // one request at a time, sent in offer order, so the caller's sequence holds
          reqNext = reqIn;
          if (reqIn.addCrc3) begin
            reqNext.cmd[2:0] = crc3(reqIn.cmd[15:3]);
          end
          rdNext    = 1'b0;
          idxNext   = 4'h0;
          pendNext  = (reqIn.words != 3'h0);
          refNext   = 1'b0;
          txNext    = {`DEV_ADDR, `WRITE_BIT, 1'b1};
          cntNext   = TW'(`SU_STA_CYC);
          stateNext = S_START;
        end
      end
      S_START: begin
        if (!sclSync) begin
          cntNext = TW'(`SU_STA_CYC);
        end else if (cntZero && sdaOeReg) begin
          sdaOeNext = 1'b0;
          cntNext   = TW'(`HD_STA_CYC);
        end else if (cntZero) begin
          sclOeNext = 1'b0;
          bitNext   = 4'h0;
          cntNext   = TW'(`LOW_CYC);
          stateNext = S_LOW;
        end
      end
      S_LOW: begin
        // data changes one cycle after scl falls, giving hold margin
        sdaOeNext = txReg[8];
        if (cntZero) begin
          sclOeNext = 1'b1;
          cntNext   = TW'(`HIGH_CYC);
          stateNext = S_HIGH;
        end
      end
      S_HIGH: begin
        // the high phase counts only once scl is really high (stretching)
        if (!sclSync) begin
          cntNext = TW'(`HIGH_CYC);
        end else if (cntZero) begin
          rxNext    = {rxReg[7:0], sdaSync};
          txNext    = {txReg[7:0], 1'b1};
          sclOeNext = 1'b0;
          cntNext   = TW'(`LOW_CYC);
          if (bitReg == `BIT_LAST) begin
            stateNext = S_NEXT;
          end else begin
            bitNext   = bitReg + 4'h1;
            stateNext = S_LOW;
          end
        end
      end
      S_NEXT: begin
        cntNext = TW'(`LOW_CYC);
        bitNext = 4'h0;
        if (!rdReg) begin
          if (!ackSeen) begin
            refNext   = 1'b1;
            pendNext  = 1'b0;
            stateNext = S_STOP;
          end else if (idxReg == (reqReg.hasData ? `IDX_DATA_CRC : `IDX_CMD_LAST)) begin
            stateNext = S_STOP;
          end else begin
            idxNext   = idxReg + 4'h1;
            txNext    = {wrByte, 1'b1};
            stateNext = S_LOW;
          end
        end else if (idxReg == 4'h0) begin
          if (!ackSeen) begin
            stateNext = S_STOP;
          end else begin
            idxNext   = 4'h1;
            posNext   = 2'h0;
            leftNext  = reqReg.words;
            txNext    = {8'hFF, 1'b0};
            stateNext = S_LOW;
          end
        end else if (posReg == 2'h2 && !fifoInReady) begin
          // hold scl low until the consumer makes room
          stateNext = S_NEXT;
        end else begin
          if (posReg == 2'h0) begin
            wordNext[15:8] = rxReg[8:1];
          end else if (posReg == 2'h1) begin
            wordNext[7:0] = rxReg[8:1];
          end else begin
            push = 1'b1;
          end
          if (posReg == 2'h2 && leftReg == 3'h1) begin
            pendNext  = 1'b0;
            stateNext = S_STOP;
          end else begin
            idxNext   = idxReg + 4'h1;
            posNext   = nPos;
            leftNext  = nLeft;
            txNext    = {8'hFF, (nPos == 2'h2 && nLeft == 3'h1)};
            stateNext = S_LOW;
          end
        end
      end
      S_STOP: begin
        if (!sclOeReg) begin
          sdaOeNext = 1'b0;
          if (cntZero) begin
            sclOeNext = 1'b1;
            cntNext   = TW'(`SU_STO_CYC);
          end
        end else if (!sdaOeReg) begin
          if (!sclSync) begin
            cntNext = TW'(`SU_STO_CYC);
          end else if (cntZero) begin
            sdaOeNext = 1'b1;
            cntNext   = TW'(`BUF_CYC);
          end
        end else if (cntZero) begin
          if (pendReg) begin
            cntNext   = rdReg ? TW'(POLL_CYC) : TW'(MEAS_CYC);
            stateNext = S_WAIT;
          end else begin
            doneNext  = 1'b1;
            stateNext = S_IDLE;
          end
        end
      end
      S_WAIT: begin
        if (cntZero) begin
          rdNext    = 1'b1;
          idxNext   = 4'h0;
          txNext    = {`DEV_ADDR, `READ_BIT, 1'b1};
          cntNext   = TW'(`SU_STA_CYC);
          stateNext = S_START;
        end
      end
      default: begin
        sclOeNext = 1'b1;
        sdaOeNext = 1'b1;
        stateNext = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stateReg   <= S_PWRUP;
      reqReg     <= '0;
      cntReg     <= TW'(PWRUP_CYC);
      bitReg     <= '0;
      idxReg     <= '0;
      txReg      <= '1;
      rxReg      <= '1;
      posReg     <= '0;
      leftReg    <= '0;
      wordReg    <= '0;
      rdReg      <= 1'b0;
      pendReg    <= 1'b0;
      refReg     <= 1'b0;
      sclOeReg   <= 1'b1;
      sdaOeReg   <= 1'b1;
      doneReg    <= 1'b0;
      readyReg   <= 1'b0;
      busyReg    <= 1'b0;
      loadReg    <= 1'b0;
      sclSyncReg <= 2'h3;
      sdaSyncReg <= 2'h3;
    end else begin
      stateReg   <= stateNext;
      reqReg     <= reqNext;
      cntReg     <= cntNext;
      bitReg     <= bitNext;
      idxReg     <= idxNext;
      txReg      <= txNext;
      rxReg      <= rxNext;
      posReg     <= posNext;
      leftReg    <= leftNext;
      wordReg    <= wordNext;
      rdReg      <= rdNext;
      pendReg    <= pendNext;
      refReg     <= refNext;
      sclOeReg   <= sclOeNext;
      sdaOeReg   <= sdaOeNext;
      doneReg    <= doneNext;
      readyReg   <= (stateNext == S_IDLE) && !(reqValid && readyReg);
      busyReg    <= (stateNext != S_IDLE) && (stateNext != S_PWRUP);
      loadReg    <= (stateReg == S_NEXT) && (stateNext == S_LOW);
      sclSyncReg <= {sclSyncReg[0], sclIn};
      sdaSyncReg <= {sdaSyncReg[0], sdaIn};
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_power_wait: assert property (stateReg == S_PWRUP |-> !readyReg)
    else $error("request accepted during power-up");
  chk_addr_header: assert property ($rose(stateReg == S_START) |-> txReg[8:2] == `DEV_ADDR)
    else $error("header carries wrong address");
  chk_write_header: assert property ($rose(stateReg == S_START) && !rdReg |-> !txReg[1])
    else $error("command header not a write");
  chk_cmd_byte: assert property (loadReg && !rdReg && idxReg == `IDX_CMD_MSB
                                 |-> txReg[8:1] == reqReg.cmd[15:8])
    else $error("command high byte wrong");
  chk_data_crc: assert property (loadReg && !rdReg && idxReg == `IDX_DATA_CRC
                                 |-> txReg[8:1] == crc8(reqReg.data))
    else $error("data checksum byte wrong");
  chk_read_ack: assert property (loadReg && rdReg && idxReg != 4'h0
                                 |-> txReg[0] == (posReg == 2'h2 && leftReg == 3'h1))
    else $error("host ack bit wrong");
  chk_stop_last: assert property (stateReg == S_NEXT && rdReg && idxReg != 4'h0 && posReg == 2'h2
                                  && leftReg == 3'h1 && fifoInReady
                                  |=> stateReg == S_STOP ##1 !sdaOeReg)
    else $error("no stop after final checksum");
  chk_sda_steady: assert property (stateReg == S_HIGH && $past(stateReg) == S_HIGH
                                   |-> $stable(sdaOeReg))
    else $error("sda moved while scl high");
  chk_start_cond: assert property ($fell(sdaOeReg) && sclOeReg |-> stateReg == S_START)
    else $error("sda fell with scl high outside start");
  chk_poll_retry: assert property (stateReg == S_NEXT && rdReg && idxReg == 4'h0 && !ackSeen
                                   |=> stateReg == S_STOP ##[100:300] stateReg == S_WAIT)
    else $error("refused read header not retried");
  chk_meas_hold: assert property (stateReg == S_WAIT && !cntZero |=> stateReg == S_WAIT)
    else $error("measurement wait cut short");
endmodule : gas_sensor_host

/* File: verif/gas_sensor_model.sv */
// behavioural gas sensor target on the open-drain bus
`timescale 1ns/1ps
module gas_sensor_model #(
  parameter logic [6:0] ADDR       = 7'h58,
  parameter int         RESP_WORDS = 2,
  parameter int         MEAS_NS    = 60000,
  parameter int         PU_NS      = 400,
  parameter logic [7:0] CRC8_POLY  = 8'h07,
  parameter logic [7:0] CRC8_INIT  = 8'h00,
  parameter logic [2:0] CRC3_POLY  = 3'h3,
  parameter logic [2:0] CRC3_INIT  = 3'h0
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sdaLow
);
  logic [7:0]  bytes [0:15];
  logic [15:0] lastCmd;
  logic        rd, ulp, dataOk, fresh;
  int          k, nRefused, nStart, nStop;
  realtime     measEnd, tAck;

  // checksum generators, polynomial and init as parameters
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC8_INIT;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC8_POLY : 8'h00);
    return c;
  endfunction : crc8

  function automatic logic [2:0] crc3(input logic [12:0] d);
    logic [2:0] c;
    c = CRC3_INIT;
    for (int i = 12; i >= 0; i--) c = {c[1:0], 1'b0} ^ ((c[2] ^ d[i]) ? CRC3_POLY : 3'h0);
    return c;
  endfunction : crc3

  // each routine starts and ends just after a falling scl edge
  task automatic getByte(output logic [7:0] b);
    #200 sdaLow = 1'b0;
    repeat (8) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
    @(negedge scl);
  endtask : getByte

  task automatic giveAck(input logic a);
    #200 sdaLow = a;
    @(negedge scl);
  endtask : giveAck

  task automatic putByte(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) begin
      #200 sdaLow = ~b[i];
      @(negedge scl);
    end
    #200 sdaLow = 1'b0;
    @(posedge scl);
    a = ~sda;
    @(negedge scl);
  endtask : putByte

  task automatic frame();
    logic [7:0]  b;
    logic        a, live;
    logic [15:0] v;
    int          j;
    @(negedge scl);
    getByte(b);
    a = b[7:1] == ADDR && $realtime >= PU_NS && $realtime >= measEnd;
    if (!a) nRefused++;
    giveAck(a);
    k = 1;
    rd = b[0];
    while (a && !rd) begin
      getByte(b);
      bytes[k] = b;
      if (k == 2) begin
        lastCmd = {bytes[1], b};
        tAck = $realtime;
      end
      a = (k != 5) || (b == crc8({bytes[3], bytes[4]}));
      dataOk = a;
      giveAck(a);
      k++;
    end
    while (a && rd) begin
      j = k - 1;
      v = 16'hbe00 + 16'(j / 3) * 16'h0111;
      live = fresh && (j / 3 < RESP_WORDS);
      b = !live ? 8'hff : (j % 3 == 0) ? v[15:8] : (j % 3 == 1) ? v[7:0] : crc8(v);
      putByte(b, a);
      k++;
    end
    wait (1'b0);
  endtask : frame

  initial begin
    sdaLow = 1'b0;
    ulp = 1'b0;
    fresh = 1'b0;
    dataOk = 1'b0;
    measEnd = 0;
    nRefused = 0;
    nStart = 0;
    nStop = 0;
    forever begin
      @(negedge sda iff scl === 1'b1);
      nStart++;
      k = 0;
      rd = 1'b0;
      fork
        frame();
        @(posedge sda iff scl === 1'b1);
      join_any
      disable fork;
      sdaLow = 1'b0;
      nStop++;
      // measuring time counts from the command acknowledge
      if (!rd && k == 3) begin
        measEnd = tAck + MEAS_NS;
        fresh = 1'b1;
      end
      if (rd && k > 1) fresh = 1'b0;
      if (!rd && k == 6 && dataOk) begin
        v16Mode({bytes[3], bytes[4]});
      end
    end
  end

  task automatic v16Mode(input logic [15:0] d);
    if (d == 16'h0000) ulp = 1'b1;
    else if (d == 16'h0001) ulp = 1'b0;
  endtask : v16Mode
endmodule : gas_sensor_model

/* File: verif/gas_sensor_host_test.sv */
// self-checking bench for the gas sensor bus host
`timescale 1ns/1ps
module gas_sensor_host_test;
  import gas_host_pkg::*;
  localparam int LIM = 40000;
  logic  ref_clk, rst_n, reqValid, reqReady, respValid, respReady, busy;
  logic  donePulse, refusedErr, sclOut, sclOe_n, sdaOut, sdaOe_n, devSdaLow;
  req_t  reqIn;
  word_t respOut;
  int    fails, nTests;
  // both lines have a pull-up, so a released line reads high
  wire   sclW = (sclOe_n !== 1'b0);
  wire   sdaW = (sdaOe_n !== 1'b0) && (devSdaLow !== 1'b1);

  gas_sensor_host #(.PWRUP_CYC(20), .MEAS_CYC(200), .POLL_CYC(100)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reqIn(reqIn), .reqValid(reqValid),
    .reqReady(reqReady), .respOut(respOut), .respValid(respValid),
    .respReady(respReady), .busy(busy), .donePulse(donePulse),
    .refusedErr(refusedErr), .sclIn(sclW), .sclOut(sclOut), .sclOe_n(sclOe_n),
    .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n)
  );

  gas_sensor_model dev (.scl(sclW), .sda(sdaW), .sdaLow(devSdaLow));

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  task automatic timeout();
    fails++;
    $display("unexpected at %0t: wait ran out", $time);
    wrap_up();
  endtask : timeout

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    nTests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic issue(input logic [15:0] c, input logic hd, input logic [15:0] d,
                       input logic [2:0] w);
    int n;
    n = 0;
    // raise the request just after an edge so reqReady is judged before the taking edge
    @(posedge ref_clk);
    reqIn <= '{c, 1'b1, hd, d, w};
    reqValid <= 1'b1;
    do begin
      @(negedge ref_clk);
      n++;
    end while (reqReady !== 1'b1 && n < LIM);
    if (n >= LIM) timeout();
    @(posedge ref_clk);
    reqValid <= 1'b0;
    @(negedge ref_clk);
    check({busy, reqReady}, 2'b10, "busy after accept");
  endtask : issue

  task automatic waitDone();
    int n;
    n = 0;
    while (donePulse !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n >= LIM) timeout();
    end
    check(dev.nStart, dev.nStop, "start and stop pairs");
  endtask : waitDone

  task automatic pop(input logic [15:0] v, input logic ok);
    int n;
    n = 0;
    while (respValid !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n >= LIM) timeout();
    end
    check(respOut, {v, ok}, "result word");
    @(posedge ref_clk);
    respReady <= 1'b1;
    @(posedge ref_clk);
    respReady <= 1'b0;
    @(negedge ref_clk);
  endtask : pop

  task automatic checkPowerUp();
    int n;
    n = 0;
    check({reqReady, busy, respValid, refusedErr}, 4'h0, "reset outputs");
    while (reqReady !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    check(n >= 19 && n <= 23, 1, "power-up wait");
  endtask : checkPowerUp

  task automatic checkModes();
    check(dev.ulp, 0, "default mode");
    issue(16'h2070, 1'b1, 16'h0000, 3'h0);
    waitDone();
    check({dev.ulp, dev.dataOk, refusedErr}, 3'h6, "ultra-low mode");
    check(dev.lastCmd, {13'h040e, dev.crc3(13'h040e)}, "command checksum");
    issue(16'h2070, 1'b1, 16'h0001, 3'h0);
    waitDone();
    check({dev.ulp, dev.dataOk}, 2'h1, "low mode");
  endtask : checkModes

  task automatic checkMeasure();
    int r;
    r = dev.nRefused;
    issue(16'h2008, 1'b0, 16'h0000, 3'h2);
    waitDone();
    check(dev.nRefused > r, 1, "polled while measuring");
    for (int i = 0; i < 2; i++) pop(16'hbe00 + 16'(i) * 16'h0111, 1'b1);
    check(respValid, 0, "fifo empty");
  endtask : checkMeasure

  task automatic checkFifo();
    int n, low;
    logic ffOk;
    n = 0;
    low = 0;
    ffOk = (dev.crc8(16'hffff) === 8'hff);
    issue(16'h2008, 1'b0, 16'h0000, 3'h5);
    // a full fifo makes the host hold scl low far beyond one low phase
    while (low < 400 && n < LIM) begin
      @(negedge ref_clk);
      n++;
      low = sclW ? 0 : low + 1;
    end
    check(low >= 400 && respValid === 1'b1, 1, "stall on full fifo");
    for (int i = 0; i < 2; i++) pop(16'hbe00 + 16'(i) * 16'h0111, 1'b1);
    for (int i = 0; i < 3; i++) pop(16'hffff, ffOk);
    waitDone();
    check(respValid, 0, "fifo drained");
  endtask : checkFifo

  task automatic checkRefusal();
    issue(16'h2008, 1'b0, 16'h0000, 3'h0);
    waitDone();
    check(refusedErr, 0, "measure write taken");
    issue(16'h2008, 1'b0, 16'h0000, 3'h0);
    waitDone();
    check(refusedErr, 1, "write refused while measuring");
    // let the model's measuring time run out before the next write
    repeat (3500) @(negedge ref_clk);
    issue(16'h2070, 1'b1, 16'h0001, 3'h0);
    waitDone();
    check(refusedErr, 0, "refusal cleared");
  endtask : checkRefusal

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    respReady = 1'b0;
    reqIn = '0;
    fails = 0;
    nTests = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    checkPowerUp();
    checkModes();
    checkMeasure();
    checkFifo();
    checkRefusal();
    wrap_up();
  end
endmodule : gas_sensor_host_test
